// File: src/tmc_pkg.sv
// constants, field layout and state types for the two-timer mode block
// assumes one 100 MHz clock and word-wide AHB-Lite register access
// What this block does
// RULE1 - count pin sampled each cycle, high-low counts
// RULE2 - edge recognition spans two machine cycles
// RULE3 - source holds each level one cycle
// RULE4 - timer one gated by irq pin and run
// RULE5 - bit six picks timer one source
// RULE6 - option 00: prescaler feeds 8-bit high byte
// RULE7 - option 01: bytes cascade into 16 bits
// RULE8 - option 10: low byte reloads from high
// RULE9 - option 11 stops timer one entirely
// RULE10 - timer zero gated by irq pin and run
// RULE11 - bit two picks timer zero source
// RULE12 - timer zero options mirror timer one
// RULE13 - split: zero high byte runs on one's run
// RULE14 - timer ticks once per core clock
// RULE15 - overflow sets flag, vector ack clears
package tmc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] TMC_IDX_CTRL = 8'h88; // run bits and flags
  localparam logic [7:0] TMC_IDX_MODE = 8'h89; // timer_mode_select
  localparam logic [7:0] TMC_IDX_TL0  = 8'h8A; // timer_zero_low_byte
  localparam logic [7:0] TMC_IDX_TL1  = 8'h8B; // timer_one_low_byte
  localparam logic [7:0] TMC_IDX_TH0  = 8'h8C; // timer_zero_high_byte
  localparam logic [7:0] TMC_IDX_TH1  = 8'h8D; // timer_one_high_byte
  localparam logic [7:0] TMC_IDX_NONE = 8'h00; // unmapped access

  // address slicing for word access
  localparam int TMC_IDX_LSB = 2;
  localparam int TMC_IDX_W   = 8;
  localparam int TMC_ADR_W   = 32;

  // mode register fields
  localparam int TMC_GATE1   = 7;
  localparam int TMC_SRC1    = 6;
  localparam int TMC_OPT1_HI = 5;
  localparam int TMC_OPT1_LO = 4;
  localparam int TMC_GATE0   = 3;
  localparam int TMC_SRC0    = 2;
  localparam int TMC_OPT0_HI = 1;
  localparam int TMC_OPT0_LO = 0;

  // control register fields
  localparam int TMC_TF1 = 7;
  localparam int TMC_TR1 = 6;
  localparam int TMC_TF0 = 5;
  localparam int TMC_TR0 = 4;

  // reset values and byte constants
  localparam logic [7:0] TMC_MODE_RST = 8'h00;
  localparam logic [7:0] TMC_BYTE_RST = 8'h00;
  localparam logic [7:0] TMC_BYTE_MAX = 8'hFF;
  localparam logic [7:0] TMC_BYTE_ONE = 8'h01;
  localparam int         TMC_PRE_W    = 5;   // prescaler width

  // operating option of one timer, in bit-pattern order
  typedef enum logic [1:0] {
    TMC_PRESCALE,
    TMC_CASCADE,
    TMC_RELOAD,
    TMC_SPLIT
  } tmc_mode_t;

  // state of the main block
  typedef struct packed {
    logic [7:0] mode;  // timer_mode_select
    logic       tr0;   // timer_zero_run_bit
    logic       tr1;   // timer_one_run_bit
    logic       tf0;   // timer zero overflow flag
    logic       tf1;   // timer_one_overflow_flag
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
  } tmc_state_t;

  // state of the falling-edge sampler
  typedef struct packed {
    logic samp;  // this cycle's sample
    logic prev;  // last cycle's sample
  } tmc_fall_t;

  // state of the bus slave
  typedef struct packed {
    logic       act;    // data phase pending
    logic       wr;     // pending phase is a write
    logic       rdok;   // read data captured
    logic [7:0] idx;    // decoded register index
    logic [7:0] rdata;  // captured read byte
  } tmc_ahb_t;

endpackage : tmc_pkg

// File: src/tmc_reg_if.sv
// register access carrier between the bus slave and the timer core
// assumes both ends share clk; one access per data phase
interface tmc_reg_if;
  logic       wr_en;  // one-cycle write strobe
  logic [7:0] idx;    // register index of the data phase
  logic [7:0] wdata;  // write byte
  logic [7:0] rdata;  // read byte for idx, combinational

  // bus slave side
  modport bus (output wr_en, output idx, output wdata, input rdata);
  // register side
  modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface : tmc_reg_if

// File: src/tmc_fall.sv
// falling-edge sampler for one external count pin
// assumes the pin is already synchronous to clk
module tmc_fall
  import tmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      fall
);

  tmc_fall_t q;  // registered samples
  tmc_fall_t d;  // next samples

  // RULE1 sample every cycle
  always_comb begin
    d      = q;
    d.samp = pin;
    d.prev = q.samp;
  end

  // samples start low: a low pin after reset must not look like a fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{samp: 1'b0, prev: 1'b0};
    end else begin
      q <= d;
    end
  end

  // RULE2 high then low
  assign fall = q.prev & ~q.samp;

endmodule : tmc_fall

// File: src/tmc_ahb.sv
// AHB-Lite slave front end for the timer registers
// assumes single word transfers; reads take one wait state
module tmc_ahb
  import tmc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [TMC_ADR_W-1:0] haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  tmc_reg_if.bus                    rif
);

  tmc_ahb_t q;  // registered phase state
  tmc_ahb_t d;  // next phase state

  // word index, or none for an unaligned address or one beyond the index field
  function automatic logic [7:0] tmc_decode(logic [TMC_ADR_W-1:0] a);
    logic hi_zero;
    hi_zero = (a[TMC_ADR_W-1:TMC_IDX_LSB+TMC_IDX_W] == '0);
    if (hi_zero && a[TMC_IDX_LSB-1:0] == '0) begin
      return a[TMC_IDX_LSB+TMC_IDX_W-1:TMC_IDX_LSB];
    end
    return TMC_IDX_NONE;
  endfunction : tmc_decode

  // address phase capture and read data capture
  always_comb begin
    d = q;
    // read byte is flopped first, so reads stall once
    if (q.act && !q.wr && !q.rdok) begin
      d.rdata = rif.rdata;
      d.rdok  = 1'b1;
    end
    if (hready) begin
      d.act = 1'b0;
      // only NONSEQ or SEQ start a transfer; size is not checked
      if (hsel && htrans[1]) begin
        d.act  = 1'b1;
        d.wr   = hwrite;
        d.rdok = 1'b0;
        d.idx  = tmc_decode(haddr);
      end
    end
  end

  // phase registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // writes finish with no wait; reads wait for the captured byte
  assign hreadyout = ~(q.act & ~q.wr & ~q.rdok);
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, q.rdata};
  assign rif.wr_en = q.act & q.wr;
  assign rif.idx   = q.idx;
  assign rif.wdata = hwdata[7:0];

endmodule : tmc_ahb

// File: src/tmc_top.sv
// timer zero and timer one core: mode decode, gating, sources, counting
// assumes synchronous pins and one machine cycle per clk period
//
// Implementation choice: register access over AHB-Lite.
module tmc_top
  import tmc_pkg::*;
#(
  parameter int PRE_W = TMC_PRE_W  // prescaler width in option 00
)(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [TMC_ADR_W-1:0] haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // external pins
  input  wire logic                 count_pin_zero,
  input  wire logic                 count_pin_one,
  input  wire logic                 ext_irq_zero_pin,
  input  wire logic                 ext_irq_one_pin,
  // interrupt vector acknowledges
  input  wire logic                 tf0_vector_ack,
  input  wire logic                 tf1_vector_ack,
  // overflow flags
  output logic                      timer_zero_overflow_flag,
  output logic                      timer_one_overflow_flag
);

  // prescaler must fit inside the low byte
  if (PRE_W < 1 || PRE_W > 8) begin : g_pre_check
    $error("PRE_W must lie between 1 and 8");
  end

  tmc_reg_if rif ();  // register access from the slave

  tmc_state_t q;  // registered core state
  tmc_state_t d;  // next core state

  logic fall0;  // falling edge seen on count_pin_zero
  logic fall1;  // falling edge seen on count_pin_one

  // bus slave
  tmc_ahb u_ahb (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rif       (rif)
  );

  // RULE1 timer zero pin sampler
  tmc_fall u_fall0 (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (count_pin_zero),
    .fall  (fall0)
  );

  // RULE1 timer one pin sampler
  tmc_fall u_fall1 (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (count_pin_one),
    .fall  (fall1)
  );

  // one tick of a non-split timer: returns {overflow, high, low}
  function automatic logic [16:0] tmc_step(
    tmc_mode_t  m,
    logic [7:0] tl,
    logic [7:0] th
  );
    logic [7:0]  nl;
    logic [7:0]  nh;
    logic        ov;
    logic [15:0] both;
    nl   = tl;
    nh   = th;
    ov   = 1'b0;
    both = {th, tl};
    unique case (m)
      // low bits prescale, carry into the high byte
      TMC_PRESCALE: begin
        if (tl[PRE_W-1:0] == '1) begin
          nl[PRE_W-1:0] = '0;
          nh = th + TMC_BYTE_ONE;
          ov = (th == TMC_BYTE_MAX);
        end else begin
          nl[PRE_W-1:0] = tl[PRE_W-1:0] + 1'b1;
        end
      end
      // both bytes as one word
      TMC_CASCADE: begin
        both = both + 16'h0001;
        nl   = both[7:0];
        nh   = both[15:8];
        ov   = ({th, tl} == 16'hFFFF);
      end
      // low byte wraps to the high byte
      TMC_RELOAD: begin
        if (tl == TMC_BYTE_MAX) begin
          nl = th;
          ov = 1'b1;
        end else begin
          nl = tl + TMC_BYTE_ONE;
        end
      end
      // split is handled by the caller
      TMC_SPLIT: begin
        nl = tl;
      end
    endcase
    return {ov, nh, nl};
  endfunction : tmc_step

  // decoded mode fields
  tmc_mode_t opt0;     // timer zero option
  tmc_mode_t opt1;     // timer one option
  logic      run0;     // timer zero enabled
  logic      run1;     // timer one enabled
  logic      tick0;    // timer zero counts this cycle
  logic      tick1;    // timer one counts this cycle
  logic      ovf0;     // timer zero overflow
  logic      ovf1;     // timer one overflow
  logic      ovfh;     // split high byte overflow
  logic [16:0] st0;    // timer zero step result
  logic [16:0] st1;    // timer one step result

  // RULE12 same option decode
  assign opt0 = tmc_mode_t'(q.mode[TMC_OPT0_HI:TMC_OPT0_LO]);
  assign opt1 = tmc_mode_t'(q.mode[TMC_OPT1_HI:TMC_OPT1_LO]);

  // RULE10 gate on irq zero
  assign run0 = q.tr0 & (~q.mode[TMC_GATE0] | ext_irq_zero_pin);
  // RULE4 gate on irq one
  assign run1 = q.tr1 & (~q.mode[TMC_GATE1] | ext_irq_one_pin);

  // RULE11 zero source select
  // RULE14 machine cycle tick
  assign tick0 = run0 & (q.mode[TMC_SRC0] ? fall0 : 1'b1);
  // RULE5 one source select
  // RULE3 pin levels held long
  assign tick1 = run1 & (q.mode[TMC_SRC1] ? fall1 : 1'b1);

  // step results, used only when the tick is present
  assign st0 = tmc_step(opt0, q.tl0, q.th0);
  assign st1 = tmc_step(opt1, q.tl1, q.th1);

  // next state: counting, then software writes, then flags
  always_comb begin
    d    = q;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovfh = 1'b0;

    // timer zero
    if (opt0 == TMC_SPLIT) begin
      // RULE13 low byte on own controls
      if (tick0) begin
        d.tl0 = q.tl0 + TMC_BYTE_ONE;
        ovf0  = (q.tl0 == TMC_BYTE_MAX);
      end
      // RULE13 high byte on run one
      if (q.tr1) begin
        d.th0 = q.th0 + TMC_BYTE_ONE;
        ovfh  = (q.th0 == TMC_BYTE_MAX);
      end
    end else if (tick0) begin
      // RULE6 RULE7 RULE8 zero options
      {ovf0, d.th0, d.tl0} = st0;
    end

    // RULE9 option 11 holds
    if (opt1 != TMC_SPLIT && tick1) begin
      // RULE6 RULE7 RULE8 one options
      {ovf1, d.th1, d.tl1} = st1;
    end

    // software write beats a count in the same cycle
    if (rif.wr_en) begin
      unique case (rif.idx)
        TMC_IDX_MODE: d.mode = rif.wdata;
        TMC_IDX_CTRL: begin
          d.tf1 = rif.wdata[TMC_TF1];
          d.tr1 = rif.wdata[TMC_TR1];
          d.tf0 = rif.wdata[TMC_TF0];
          d.tr0 = rif.wdata[TMC_TR0];
        end
        TMC_IDX_TL0:  d.tl0 = rif.wdata;
        TMC_IDX_TL1:  d.tl1 = rif.wdata;
        TMC_IDX_TH0:  d.th0 = rif.wdata;
        TMC_IDX_TH1:  d.th1 = rif.wdata;
        // unmapped writes are dropped
        default: d.mode = d.mode;
      endcase
    end

    // vector ack clears, but an overflow in the same cycle wins
    if (tf0_vector_ack) begin
      d.tf0 = 1'b0;
    end
    if (tf1_vector_ack) begin
      d.tf1 = 1'b0;
    end
    // RULE15 overflow sets flag
    if (ovf0) begin
      d.tf0 = 1'b1;
    end
    // split high byte borrows timer one's flag
    if (ovf1 || ovfh) begin
      d.tf1 = 1'b1;
    end
  end

  // core state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{mode: TMC_MODE_RST, tr0: 1'b0, tr1: 1'b0,
             tf0: 1'b0, tf1: 1'b0,
             tl0: TMC_BYTE_RST, th0: TMC_BYTE_RST,
             tl1: TMC_BYTE_RST, th1: TMC_BYTE_RST};
    end else begin
      q <= d;
    end
  end

  // read mux; unused control bits and unmapped words read zero
  always_comb begin
    rif.rdata = TMC_BYTE_RST;
    unique case (rif.idx)
      TMC_IDX_MODE: rif.rdata = q.mode;
      TMC_IDX_CTRL: begin
        rif.rdata[TMC_TF1] = q.tf1;
        rif.rdata[TMC_TR1] = q.tr1;
        rif.rdata[TMC_TF0] = q.tf0;
        rif.rdata[TMC_TR0] = q.tr0;
      end
      TMC_IDX_TL0:  rif.rdata = q.tl0;
      TMC_IDX_TL1:  rif.rdata = q.tl1;
      TMC_IDX_TH0:  rif.rdata = q.th0;
      TMC_IDX_TH1:  rif.rdata = q.th1;
      default:      rif.rdata = TMC_BYTE_RST;
    endcase
  end

  // flags straight from their flops
  assign timer_zero_overflow_flag = q.tf0;
  assign timer_one_overflow_flag  = q.tf1;

endmodule : tmc_top

// File: sim/tmc_properties.sv
// bus and flag checks on the timer block's top ports
// assumes hready is looped back from hreadyout
module tmc_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        tf0_vector_ack,
  input wire logic        tf1_vector_ack,
  input wire logic        timer_zero_overflow_flag,
  input wire logic        timer_one_overflow_flag
);
  logic take;     // transfer accepted this cycle
  logic rd_take;  // read accepted this cycle
  logic wr_dp_q;  // write data phase under way
  assign take = hready && hsel && htrans[1];
  assign rd_take = take && !hwrite;
  // software may rewrite flags at write end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_dp_q <= 1'b0;
    else if (hready) wr_dp_q <= take && hwrite;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rd_wait; rd_take |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_go; take && hwrite |=> hreadyout; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_wait_why; $fell(hreadyout) |-> $past(rd_take); endproperty
  a_wait_why: assert property (p_wait_why) else $error("stray wait");
  property p_hi_zero; hrdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
  property p_rd_hold; $changed(hrdata) |-> $past(rd_take, 2); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_tf1_hold;
    timer_one_overflow_flag && !tf1_vector_ack && !wr_dp_q
      |=> timer_one_overflow_flag;
  endproperty
  a_tf1_hold: assert property (p_tf1_hold) else $error("flag1 lost")
  ;
  property p_tf0_hold;
    timer_zero_overflow_flag && !tf0_vector_ack && !wr_dp_q
      |=> timer_zero_overflow_flag;
  endproperty
  a_tf0_hold: assert property (p_tf0_hold) else $error("flag0 lost")
  ;
endmodule : tmc_properties

// File: sim/tmc_pins.sv
// far-side model: count sources and gate pins
// assumes each call starts right after a rising clk edge
module tmc_pins (
  input  wire logic clk,
  output logic      cnt0,
  output logic      cnt1,
  output logic      irq0,
  output logic      irq1
);
  // pins idle low, gates closed
  initial begin
    {cnt0, cnt1, irq0, irq1} = 4'h0;
  end
  task automatic falls(input bit ch, input int n, input int w);
    repeat (n) begin
      if (ch) cnt1 <= 1'b1; else cnt0 <= 1'b1;
      repeat (w) @(posedge clk);
      if (ch) cnt1 <= 1'b0; else cnt0 <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask : falls
  // gate open for exactly k cycles
  task automatic gate(input bit ch, input int k);
    if (ch) irq1 <= 1'b1; else irq0 <= 1'b1;
    repeat (k) @(posedge clk);
    if (ch) irq1 <= 1'b0; else irq0 <= 1'b0;
  endtask : gate
endmodule : tmc_pins

// File: sim/timer01_mode_and_count_input_test.sv
// self-checking bench for the two-timer mode block
// assumes one AHB-Lite master and the pin model
module timer01_mode_and_count_input_test
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, hsel, hwrite, ack0, ack1;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hreadyout, hresp, tf0, tf1, c0, c1, i0, i1;
  int          miscompares, comparisons;
  tmc_top u_tmc_top (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_pin_zero(c0),
    .count_pin_one(c1), .ext_irq_zero_pin(i0), .ext_irq_one_pin(i1),
    .tf0_vector_ack(ack0), .tf1_vector_ack(ack1),
    .timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1));
  tmc_pins u_tmc_pins (.clk(clk), .cnt0(c0), .cnt1(c1), .irq0(i0),
    .irq1(i1));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // one single transfer; ready looked at before each edge
  task automatic xfer(input logic w, input logic [7:0] ix,
                      input logic [7:0] d, output logic [31:0] r);
    logic rdy;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'b00};
    do begin
      @(negedge clk) rdy = hreadyout;
      @(posedge clk);
    end while (rdy !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do begin
      @(negedge clk) rdy = hreadyout;
      r = hrdata;
      @(posedge clk);
    end while (rdy !== 1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] ix, d);
    logic [31:0] v;
    xfer(1'b1, ix, d, v);
  endtask : wr
  task automatic rd(input logic [7:0] ix, e, input string nm);
    logic [31:0] v;
    xfer(1'b0, ix, 8'h00, v);
    check(nm, v, {24'h0, e});
  endtask : rd
  // stop, set mode and counts, then start one timer
  task automatic run(input bit ch, input logic [7:0] md, lo, hi);
    wr(TMC_IDX_CTRL, 8'h00);
    wr(TMC_IDX_MODE, md);
    wr(ch ? TMC_IDX_TL1 : TMC_IDX_TL0, lo);
    wr(ch ? TMC_IDX_TH1 : TMC_IDX_TH0, hi);
    wr(TMC_IDX_CTRL, ch ? 8'h40 : 8'h10);
  endtask : run
  task automatic both(input bit ch, input logic [7:0] lo, hi);
    rd(ch ? TMC_IDX_TL1 : TMC_IDX_TL0, lo, "low byte");
    rd(ch ? TMC_IDX_TH1 : TMC_IDX_TH0, hi, "high byte");
  endtask : both
  // pulse the vector acknowledge, flag must drop
  task automatic clr(input bit ch);
    if (ch) ack1 <= 1'b1; else ack0 <= 1'b1;
    @(posedge clk);
    {ack0, ack1} <= 2'b00;
    repeat (2) @(posedge clk);
    check("flag cleared", ch ? tf1 : tf0, 1'b0);
  endtask : clr
  task automatic t_regs;
    rd(TMC_IDX_MODE, TMC_MODE_RST, "mode reset");
    rd(TMC_IDX_CTRL, 8'h00, "ctrl reset");
    wr(TMC_IDX_MODE, 8'hA5);
    rd(TMC_IDX_MODE, 8'hA5, "mode rw");
    wr(TMC_IDX_NONE, 8'h5A);
    rd(TMC_IDX_NONE, 8'h00, "unmapped");
    $display("test regs done");
  endtask : t_regs
  // gate closed six cycles, then open 37
  task automatic t_gate(input bit ch);
    run(ch, ch ? 8'h90 : 8'h09, 8'h00, 8'h00);
    repeat (6) @(posedge clk);
    u_tmc_pins.gate(ch, 37);
    both(ch, 8'h25, 8'h00);
    $display("test gate done");
  endtask : t_gate
  task automatic t_count(input bit ch, input int w, n);
    run(ch, ch ? 8'h50 : 8'h05, 8'h00, 8'h00);
    u_tmc_pins.falls(ch, n, w);
    both(ch, n[7:0], 8'h00);
    $display("test count done");
  endtask : t_count
  // top three low bits hold, carry wraps high byte
  task automatic t_prescale;
    run(1'b1, 8'h40, 8'hFE, 8'hFF);
    u_tmc_pins.falls(1'b1, 3, 1);
    both(1'b1, 8'hE1, 8'h00);
    check("flag one", tf1, 1'b1);
    clr(1'b1);
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_reload;
    run(1'b0, 8'h06, 8'hFE, 8'hF0);
    u_tmc_pins.falls(1'b0, 3, 1);
    both(1'b0, 8'hF1, 8'hF0);
    check("flag zero", tf0, 1'b1);
    clr(1'b0);
    run(1'b1, 8'h50, 8'hFF, 8'h12);
    u_tmc_pins.falls(1'b1, 1, 2);
    both(1'b1, 8'h00, 8'h13);
    $display("test reload done");
  endtask : t_reload
  task automatic t_stop;
    run(1'b1, 8'h70, 8'h33, 8'h44);
    u_tmc_pins.falls(1'b1, 4, 1);
    both(1'b1, 8'h33, 8'h44);
    check("no flag", tf1, 1'b0);
    $display("test stop done");
  endtask : t_stop
  // high byte runs seven cycles on the other run bit
  task automatic t_split;
    run(1'b0, 8'h0B, 8'h00, 8'h00);
    u_tmc_pins.gate(1'b0, 11);
    wr(TMC_IDX_CTRL, 8'h40);
    repeat (4) @(posedge clk);
    wr(TMC_IDX_CTRL, 8'h00);
    both(1'b0, 8'h0B, 8'h07);
    $display("test split done");
  endtask : t_split
  task automatic summarize;
    $display("compares %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // whole run needs a few hundred cycles
  initial begin
    #200us;
    miscompares++;
    summarize();
  end
  initial begin
    {rst_n, hsel, hwrite, ack0, ack1, htrans} = 7'h00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_gate(1'b0);
    t_gate(1'b1);
    t_count(1'b0, 1, 9);
    t_count(1'b1, 3, 5);
    t_prescale();
    t_reload();
    t_stop();
    t_split();
    summarize();
  end
endmodule : timer01_mode_and_count_input_test
bind tmc_top tmc_properties u_props (.clk, .rst_n, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .tf0_vector_ack,
  .tf1_vector_ack, .timer_zero_overflow_flag, .timer_one_overflow_flag);
